// ===== common/vco_tune_pkg.sv
/*
  Constants and carrier types for the oscillator tuning engine.
  Assumes an internal register port that carries 8-bit addresses and data.
*/
package vco_tune_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int SETTLE_UNIT_NS  = 1600;
  localparam int SETTLE_UNIT_CYC =
    (SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TUNING_CODE_OFFSET  = 8'h59;
  localparam logic [7:0] HOLD_CONTROL_OFFSET = 8'h5c;
  localparam logic [7:0] ENGINE_CTRL_OFFSET  = 8'h5d;
  localparam logic [7:0] ENGINE_STAT_OFFSET  = 8'h5e;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int HOLD_BIT_POS     = 0;
  localparam int ENABLE_BIT_POS   = 0;
  localparam int SETTLE_LSB       = 4;
  localparam int SETTLE_MSB       = 6;
  localparam int DONE_BIT_POS     = 0;
  localparam int CODE_MSB         = 6;
  localparam logic [7:0] TUNING_CODE_RESET  = 8'h00;
  localparam logic [7:0] HOLD_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ENGINE_CTRL_RESET  = 8'h40;
  localparam logic [7:0] ENGINE_STAT_RESET  = 8'h00;
  localparam logic [6:0] CODE_START         = 7'h40;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } reg_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_DECIDE = 2'b10
  } tune_state_t;

endpackage : vco_tune_pkg

// ===== core/settle_timer.sv
/*
  Down-counting settle timer for the tuning engine.
  Assumes start and length come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module settle_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  // Control
  input  wire logic         start_in,
  input  wire logic [W-1:0] length_in,
  output logic              expired_out
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start_in) begin
      cnt_d = length_in;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign expired_out = (cnt_q == W'(1)) && !start_in;

endmodule : settle_timer

`default_nettype wire

// ===== core/vco_tune_engine.sv
/*
  Register file and successive-approximation tuning engine for the
  synthesizer oscillator.
  Assumes the serial control port hands over one-cycle read and write
  strobes on clk_in, and that the oscillator frequency comparator is
  asynchronous to clk_in.
*/
// Notes on behaviour
// - A 7-bit tuning code trims the oscillator and is written by the engine or software.
// - After tuning the resulting code reads back and may be saved and rewritten.
// - With the engine enabled, tuning begins when the hold bit is written from 1 to 0.
// - The engine steps the code until the oscillator frequency is centred.
// - A 3-bit settle field, reset 4, sets the wait after each code change.
// - Status bit 0 reads 1 once the engine has finished.
// - Status bit 0 also reads 1 when hold is released with the engine off.
`timescale 1ns/1ps
`default_nettype none

module vco_tune_engine
  import vco_tune_pkg::*;
#(
  parameter int TIMER_W    = 16,
  parameter int UNIT_CYC   = SETTLE_UNIT_CYC
) (
  // Clock and reset
  input  wire logic     clk_in,
  input  wire logic     srst_in,
  // Register port
  input  wire reg_req_t req_in,
  output reg_rsp_t      rsp_out,
  // Oscillator side
  input  wire logic     osc_fast_in,
  output logic [6:0]    tuning_code_out,
  output logic          synth_hold_out,
  output logic          tuning_busy_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [6:0]  code_q,   code_d;
  logic        hold_q,   hold_d;
  logic [7:0]  ctrl_q,   ctrl_d;
  logic        done_q,   done_d;
  tune_state_t state_q,  state_d;
  logic [2:0]  bit_q,    bit_d;
  reg_rsp_t    rsp_q,    rsp_d;
  logic        busy_q,   busy_d;
  logic        fast_s1_q, fast_s2_q;

  logic               timer_start;
  logic               timer_expired;
  logic [TIMER_W-1:0] settle_len;
  logic               wr_hold, wr_ctrl, wr_code;
  logic               hold_release;
  logic               engine_en;

  // ----------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fast_s1_q <= 1'b0;
      fast_s2_q <= 1'b0;
    end else begin
      fast_s1_q <= osc_fast_in;
      fast_s2_q <= fast_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    wr_hold = 1'b0;
    wr_ctrl = 1'b0;
    wr_code = 1'b0;
    if (req_in.wr && req_in.addr == HOLD_CONTROL_OFFSET) begin
      wr_hold = 1'b1;
    end else if (req_in.wr && req_in.addr == ENGINE_CTRL_OFFSET) begin
      wr_ctrl = 1'b1;
    end else if (req_in.wr && req_in.addr == TUNING_CODE_OFFSET) begin
      wr_code = 1'b1;
    end
  end

  assign engine_en    = ctrl_q[ENABLE_BIT_POS];
  // Start only on a real 1-to-0 transition of the hold bit
  assign hold_release = wr_hold && hold_q &&
                        !req_in.wdata[HOLD_BIT_POS];
  // Wait grows with the field; zero still gives one unit
  assign settle_len   = TIMER_W'(({13'h0, ctrl_q[SETTLE_MSB:SETTLE_LSB]}
                        + 16'h1) * UNIT_CYC);

  // ----------------------------------------------------------------
  // Registers and engine, next values
  // ----------------------------------------------------------------
  always_comb begin
    code_d      = code_q;
    hold_d      = hold_q;
    ctrl_d      = ctrl_q;
    done_d      = done_q;
    state_d     = state_q;
    bit_d       = bit_q;
    timer_start = 1'b0;

    if (wr_hold) begin
      hold_d = req_in.wdata[HOLD_BIT_POS];
    end
    if (wr_ctrl) begin
      ctrl_d = req_in.wdata;
    end
    if (wr_code) begin
      code_d = req_in.wdata[CODE_MSB:0];
    end

    case (state_q)
      ST_IDLE: begin
        if (hold_release && engine_en) begin
          done_d      = 1'b0;
          code_d      = CODE_START;
          bit_d       = 3'h6;
          timer_start = 1'b1;
          state_d     = ST_SETTLE;
        end else if (hold_release) begin
          done_d = 1'b1;
        end
      end
      ST_SETTLE: begin
        if (timer_expired) begin
          state_d = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        // Too fast: drop the trial bit, binary search toward centre
        if (fast_s2_q) begin
          code_d[bit_q] = 1'b0;
        end
        if (bit_q == 3'h0) begin
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end else begin
          code_d[bit_q - 3'h1] = 1'b1;
          bit_d                = bit_q - 3'h1;
          timer_start          = 1'b1;
          state_d              = ST_SETTLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase

    // Raising hold before the final decide cycle abandons a run; done stays low
    if (state_q != ST_IDLE && wr_hold && req_in.wdata[HOLD_BIT_POS]) begin
      state_d     = ST_IDLE;
      timer_start = 1'b0;
    end
    // Busy leaves a flop so the port carries no decode glitches
    busy_d = (state_d != ST_IDLE);
  end

  // ----------------------------------------------------------------
  // Read data, registered one cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    rsp_d = '{valid: req_in.rd, rdata: 8'h00};
    if (req_in.addr == TUNING_CODE_OFFSET) begin
      rsp_d.rdata = {1'b0, code_q};
    end else if (req_in.addr == HOLD_CONTROL_OFFSET) begin
      rsp_d.rdata = {7'h00, hold_q};
    end else if (req_in.addr == ENGINE_CTRL_OFFSET) begin
      rsp_d.rdata = ctrl_q;
    end else if (req_in.addr == ENGINE_STAT_OFFSET) begin
      rsp_d.rdata = {7'h00, done_q};
    end
    if (!req_in.rd) begin
      rsp_d.rdata = rsp_q.rdata;
    end
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      code_q  <= TUNING_CODE_RESET[CODE_MSB:0];
      hold_q  <= HOLD_CONTROL_RESET[HOLD_BIT_POS];
      ctrl_q  <= ENGINE_CTRL_RESET;
      done_q  <= ENGINE_STAT_RESET[DONE_BIT_POS];
      state_q <= ST_IDLE;
      bit_q   <= 3'h0;
      rsp_q   <= '0;
      busy_q  <= 1'b0;
    end else begin
      code_q  <= code_d;
      hold_q  <= hold_d;
      ctrl_q  <= ctrl_d;
      done_q  <= done_d;
      state_q <= state_d;
      bit_q   <= bit_d;
      rsp_q   <= rsp_d;
      busy_q  <= busy_d;
    end
  end

  settle_timer #(
    .W (TIMER_W)
  ) u_timer (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .start_in    (timer_start),
    .length_in   (settle_len),
    .expired_out (timer_expired)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rsp_out         = rsp_q;
  assign tuning_code_out = code_q;
  assign synth_hold_out  = hold_q;
  assign tuning_busy_out = busy_q;

endmodule : vco_tune_engine

`default_nettype wire

// ===== tb/vco_tune_engine_properties.sv
/*
  Port checker for the oscillator tuning engine.
  Assumes a bind onto vco_tune_engine, one clock and a synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module vco_tune_engine_properties
  import vco_tune_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       srst_in,
  input wire reg_req_t   req_in,
  input wire reg_rsp_t   rsp_out,
  input wire logic       osc_fast_in,
  input wire logic [6:0] tuning_code_out,
  input wire logic       synth_hold_out,
  input wire logic       tuning_busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  wire logic wr_hold = req_in.wr && req_in.addr == HOLD_CONTROL_OFFSET;
  wire logic rd_stat = req_in.rd && req_in.addr == ENGINE_STAT_OFFSET;
  wire logic rd_code = req_in.rd && req_in.addr == TUNING_CODE_OFFSET;

  sequence run_start_s;
    $rose(tuning_busy_out);
  endsequence

  // A run that ends without hold raised again finished all 7 steps
  sequence run_done_s;
    $fell(tuning_busy_out) && !synth_hold_out;
  endsequence

  // Shortest run is 7 steps of a 2-cycle settle plus a decide cycle;
  // holds for any settle unit of 2 cycles or more
  localparam int RUN_MIN = 21;
  // Longest run at the widest settle field and the default unit
  localparam int RUN_MAX = 7 * (8 * SETTLE_UNIT_CYC + 1);

  // Runs can outlast any delay range, so their length is counted
  logic [15:0] run_len_q;
  always_ff @(posedge clk_in) begin
    if (srst_in || !tuning_busy_out) begin
      run_len_q <= 16'h0000;
    end else if (run_len_q != 16'hffff) begin
      run_len_q <= run_len_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  hold_set_a: assert property (wr_hold && req_in.wdata[0] |=> synth_hold_out)
    else $error("hold bit not set");
  start_code_a: assert property (run_start_s |-> tuning_code_out == CODE_START && !synth_hold_out)
    else $error("run start state wrong");
  start_cause_a: assert property (run_start_s |-> $past(wr_hold) && !$past(req_in.wdata[0]))
    else $error("run started without hold release");
  run_min_a: assert property (run_done_s |-> run_len_q >= RUN_MIN)
    else $error("run ended too early");
  run_max_a: assert property (tuning_busy_out |-> run_len_q < RUN_MAX)
    else $error("run lasted too long");
  rd_answer_a: assert property (req_in.rd |=> rsp_out.valid)
    else $error("read not answered");
  valid_pulse_a: assert property (rsp_out.valid |-> $past(req_in.rd))
    else $error("answer without read");
  stat_rsvd_a: assert property (rd_stat |=> rsp_out.rdata[7:1] == 7'h00)
    else $error("reserved status bits set");
  code_read_a: assert property (rd_code |=> rsp_out.rdata == {1'b0, $past(tuning_code_out)})
    else $error("code readback wrong");
  busy_done_a: assert property (rd_stat && tuning_busy_out |=> !rsp_out.rdata[0])
    else $error("done flag high during run");
endmodule : vco_tune_engine_properties

bind vco_tune_engine vco_tune_engine_properties u_props (
  .clk_in(clk_in), .srst_in(srst_in), .req_in(req_in), .rsp_out(rsp_out),
  .osc_fast_in(osc_fast_in), .tuning_code_out(tuning_code_out),
  .synth_hold_out(synth_hold_out), .tuning_busy_out(tuning_busy_out));

`default_nettype wire

// ===== tb/synth_vco_tuning_engine_tb.sv
/*
  Self-checking bench for the oscillator tuning engine.
  Assumes a short settle unit; the comparator is modelled from a target code.
*/
`timescale 1ns/1ps
`default_nettype none

module synth_vco_tuning_engine_tb;
  import vco_tune_pkg::*;
  localparam int UNIT = 2;
  logic       clk_in, srst_in, osc_fast_in, synth_hold_out, tuning_busy_out;
  logic [6:0] tuning_code_out, target;
  logic [31:0] rng;
  reg_req_t   req_in;
  reg_rsp_t   rsp_out;
  int         bad_count, num_checks, len1, len7;
  int         model [int];

  vco_tune_engine #(.UNIT_CYC(UNIT)) DUT (.clk_in(clk_in), .srst_in(srst_in),
    .req_in(req_in), .rsp_out(rsp_out), .osc_fast_in(osc_fast_in),
    .tuning_code_out(tuning_code_out), .synth_hold_out(synth_hold_out),
    .tuning_busy_out(tuning_busy_out));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // Oscillator runs too fast whenever the code is above the target
  always @(posedge clk_in) begin
    #1;
    osc_fast_in = tuning_code_out > target;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction : xorshift

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_flag(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chk_flag

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in); #1;
    req_in.wr = 1'b1; req_in.addr = a; req_in.wdata = d;
    @(posedge clk_in); #1;
    req_in.wr = 1'b0;
    if (a != ENGINE_STAT_OFFSET && model.exists(a)) model[a] = d & 8'hff;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a);
    int exp;
    exp = model.exists(a) ? model[a] : 0;
    @(posedge clk_in); #1;
    req_in.rd = 1'b1; req_in.addr = a;
    @(posedge clk_in); #1;
    req_in.rd = 1'b0;
    chk_flag(rsp_out.valid, 1'b1);
    chk(rsp_out.rdata, exp[7:0]);
  endtask : rd_chk

  task automatic run(input int s, output int len);
    rng = xorshift(rng);
    target = rng[6:0];
    wr(HOLD_CONTROL_OFFSET, 8'h01);
    chk_flag(synth_hold_out, 1'b1);
    wr(ENGINE_CTRL_OFFSET, {1'b0, s[2:0], 4'h1});
    wr(HOLD_CONTROL_OFFSET, 8'h00);
    model[ENGINE_STAT_OFFSET] = 0;
    chk_flag(tuning_busy_out, 1'b1);
    rd_chk(ENGINE_STAT_OFFSET);
    len = 0;
    while (tuning_busy_out === 1'b1 && len < 3000) begin
      @(posedge clk_in); #1;
      len++;
    end
    if (len >= 3000) begin
      bad_count++;
      print_verdict();
    end
    model[TUNING_CODE_OFFSET] = target;
    model[ENGINE_STAT_OFFSET] = 1;
    rd_chk(TUNING_CODE_OFFSET);
    rd_chk(ENGINE_STAT_OFFSET);
  endtask : run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst_in = 1'b1; req_in = '0; target = 7'h00;
    rng = 32'h6956; bad_count = 0; num_checks = 0;
    model[TUNING_CODE_OFFSET] = 0; model[HOLD_CONTROL_OFFSET] = 0;
    model[ENGINE_CTRL_OFFSET] = 'h40; model[ENGINE_STAT_OFFSET] = 0;
    repeat (5) @(posedge clk_in);
    #1 srst_in = 1'b0;
    for (int a = 32'h58; a < 32'h60; a++) rd_chk(a[7:0]);
    $display("test reset done");
    wr(HOLD_CONTROL_OFFSET, 8'h01);
    wr(ENGINE_CTRL_OFFSET, 8'h30);
    wr(HOLD_CONTROL_OFFSET, 8'h00);
    model[ENGINE_STAT_OFFSET] = 1;
    rd_chk(ENGINE_STAT_OFFSET);
    wr(HOLD_CONTROL_OFFSET, 8'h00);
    chk_flag(tuning_busy_out, 1'b0);
    wr(ENGINE_STAT_OFFSET, 8'h00);
    rd_chk(ENGINE_STAT_OFFSET);
    $display("test skip done");
    run(1, len1);
    run(7, len7);
    chk_flag(len7 > len1, 1'b1);
    wr(TUNING_CODE_OFFSET, {1'b0, rng[14:8]});
    rd_chk(TUNING_CODE_OFFSET);
    $display("test tuning done");
    // Abort: hold raised mid-run leaves done low
    wr(HOLD_CONTROL_OFFSET, 8'h01);
    wr(HOLD_CONTROL_OFFSET, 8'h00);
    repeat (10) @(posedge clk_in);
    wr(HOLD_CONTROL_OFFSET, 8'h01);
    model[ENGINE_STAT_OFFSET] = 0;
    chk_flag(tuning_busy_out, 1'b0);
    rd_chk(ENGINE_STAT_OFFSET);
    $display("test abort done");
    print_verdict();
  end
endmodule : synth_vco_tuning_engine_tb

`default_nettype wire
